// [rtl/opamp_switch_params.svh]
// Register offsets, field positions and reset values for the amplifier bank
`ifndef OPAMP_SWITCH_PARAMS_SVH
`define OPAMP_SWITCH_PARAMS_SVH

// Byte offsets
`define AMP1_STATUS_OFS     12'h000
`define AMP1_CTRL_OFS       12'h004
`define AMP2_STATUS_OFS     12'h008
`define AMP2_CTRL_OFS       12'h00c
`define AMP2_ROUTE_GAIN_OFS 12'h010
`define CMP_SRC_OFS         12'h014

// Status register field
`define STATUS_LEVEL_BIT    7

// Control register fields (both amplifiers)
`define CTRL_CMP_ROUTE_BIT  7
`define CTRL_FEEDBACK_BIT   6
`define CTRL_REF_HI_BIT     5
`define CTRL_REF_LO_BIT     4
`define CTRL_POS_PIN_BIT    3
`define CTRL_NEG_PIN_BIT    2
`define CTRL_OUT_PIN_BIT    1
`define CTRL_ENABLE_BIT     0

// Route and gain register fields
`define RG_NEG_ROUTE_BIT    7
`define RG_POS_ROUTE_BIT    6
`define RG_GAIN_EN_BIT      3
`define RG_GAIN_HI_BIT      2
`define RG_GAIN_LO_BIT      0
// Implemented bits of the route and gain word
`define RG_USED_MASK        8'hcf

// Comparator source register field
`define CMP_SRC_BIT         0

// Reset values
`define CTRL_RESET          8'h0c
`define ROUTE_GAIN_RESET    8'h00
`define CMP_SRC_RESET       1'b1

`endif

// [rtl/opamp_switch_pkg.sv]
// Types shared by the amplifier control bank
package opamp_switch_pkg;
    // Reference select code
    typedef enum logic [1:0] {
        ref_none = 2'b00,
        ref_high = 2'b01,
        ref_mid  = 2'b10,
        ref_low  = 2'b11
    } ref_sel_e;
    typedef logic [7:0] reg8_t;
    typedef logic [2:0] gain_sel_t;
endpackage

// [rtl/opamp_switch_control_regs.sv]
// Register bank and switch decode for two on-chip amplifiers
//
// Behaviour
// (R1) Status bit 7 shows output level, read-only
// (R2) Amp1 disabled forces its feedback bit low
// (R3) Amp1 positive pin write clears reference field
// (R4) Reference code: none, high, mid, low
// (R5) Amp2 disabled clears gain enable, feedback
// (R6) Amp2 positive pin write clears route, reference
// (R7) Amp2 negative pin write clears inverting route
// (R8) Gain code 000..111 means 1,8..56
// (R9) Gain applies only while gain enabled
// (R10) Software clears comparator source before amp1 route
// (R11) Software clears source, amp1 route before amp2
// (R12) Clear amp2 negative pin before inverting route
// (R13) Clear amp2 positive pin before positive route
// (R14) Clear pin, route before amp2 reference
// (R15) Comparator switch follows amp1 route bit
// (R16) Amp1 disabled holds feedback switch open
// (R17) Amp1 switches decode from control bits
// (R18) Amp1 input pins are I/O unless enabled, selected; output pin unless enabled
// (R19) Separate output enable per amplifier
// (R20) Route-gain bits 5,4 read zero
// (R21) Comparator source: 0 amplifier, 1 pin; reset 1
// (R22) Auto-clear lands with the write itself
// (R23) Switch outputs decode registers combinationally
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "opamp_switch_params.svh"

module opamp_switch_control_regs (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        amp1_out_level,
    input  wire logic                        amp2_out_level,
    output logic                             amplifier_one_en,
    output logic                             amplifier_two_en,
    output logic                             amp1_out_pin_en,
    output logic                             amp2_out_pin_en,
    output logic                             amp1_pos_pin_switch,
    output logic                             amp1_neg_pin_switch,
    output logic                             amp1_feedback_switch,
    output logic                             amp1_cmp_switch,
    output logic                             high_ref_switch,
    output logic                             mid_ref_switch,
    output logic                             low_ref_switch,
    output logic                             amp1_pos_pin_func,
    output logic                             amp1_neg_pin_func,
    output logic                             amp1_out_pin_func,
    output logic                             amp2_pos_pin_switch,
    output logic                             amp2_neg_pin_switch,
    output logic                             amp2_feedback_sw_ctl,
    output logic                             amp2_cmp_switch,
    output opamp_switch_pkg::ref_sel_e       amp2_ref_sel,
    output logic                             amp1_to_amp2_neg,
    output logic                             amp1_to_amp2_pos,
    output logic                             gain_active,
    output opamp_switch_pkg::gain_sel_t      gain_sel,
    output logic      [5:0]                  gain_value,
    output logic                             cmp_pos_src_sel
);
    import opamp_switch_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg8_t      amp1_ctrl_reg;
    reg8_t      amp2_ctrl_reg;
    reg8_t      amp2_route_gain_reg;
    logic       cmp_src;
    logic       amp1_lvl_meta;
    logic       amp1_lvl;
    logic       amp2_lvl_meta;
    logic       amp2_lvl;
    logic       wr_en;
    logic       rd_setup;
    logic       sel_amp1_status;
    logic       sel_amp1_ctrl;
    logic       sel_amp2_status;
    logic       sel_amp2_ctrl;
    logic       sel_route_gain;
    logic       sel_cmp_src;
    logic       addr_hit;
    logic       wr_low;
    reg8_t      wbyte;
    reg8_t      next_amp1_ctrl;
    reg8_t      next_amp2_ctrl;
    reg8_t      next_route_gain;
    ref_sel_e   amp1_ref;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Gain code to gain factor
    function automatic logic [5:0] gain_of(input gain_sel_t code);
        logic [5:0] g;
        g = 6'h00;
        // (R8) gain encoding
        if (code == 3'h0) begin
            g = 6'h01;
        end else begin
            g = {code, 3'h0};
        end
        return g;
    endfunction

    // Two-bit reference field of a control byte
    function automatic ref_sel_e ref_of(input reg8_t ctrl);
        ref_sel_e r;
        r = ref_sel_e'(ctrl[`CTRL_REF_HI_BIT:`CTRL_REF_LO_BIT]);
        return r;
    endfunction

    // Status byte: level in the top bit, the rest reads zero
    function automatic reg8_t status_byte(input logic lvl);
        reg8_t s;
        s = 8'h00;
        // (R1) level in bit 7
        s[`STATUS_LEVEL_BIT] = lvl;
        return s;
    endfunction

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Single-cycle access phase, no wait states
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    // Only byte lane 0 carries register data
    assign wr_low   = wr_en && pstrb[0];
    assign wbyte    = pwdata[7:0];
    // Register selects, one per mapped word
    assign sel_amp1_status = (paddr == `AMP1_STATUS_OFS);
    assign sel_amp1_ctrl   = (paddr == `AMP1_CTRL_OFS);
    assign sel_amp2_status = (paddr == `AMP2_STATUS_OFS);
    assign sel_amp2_ctrl   = (paddr == `AMP2_CTRL_OFS);
    assign sel_route_gain  = (paddr == `AMP2_ROUTE_GAIN_OFS);
    assign sel_cmp_src     = (paddr == `CMP_SRC_OFS);
    // (R1) status words hold no storage, writes fall away
    assign addr_hit = sel_amp1_status || sel_amp1_ctrl || sel_amp2_status
                   || sel_amp2_ctrl || sel_route_gain || sel_cmp_src;
    assign pslverr  = psel && penable && !addr_hit;

    // ------------------------------------------------------------------
    // Output level synchronisers
    // ------------------------------------------------------------------
    // Two flops per level since the amplifiers are asynchronous
    // Amplifier one level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp1_lvl_meta <= 1'b0;
            amp1_lvl      <= 1'b0;
        end else begin
            amp1_lvl_meta <= amp1_out_level;
            amp1_lvl      <= amp1_lvl_meta;
        end
    end

    // Amplifier two level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp2_lvl_meta <= 1'b0;
            amp2_lvl      <= 1'b0;
        end else begin
            amp2_lvl_meta <= amp2_out_level;
            amp2_lvl      <= amp2_lvl_meta;
        end
    end

    // ------------------------------------------------------------------
    // Next values with hardware interlocks
    // ------------------------------------------------------------------
    // Amplifier one control
    always_comb begin
        next_amp1_ctrl = amp1_ctrl_reg;
        if (wr_low && sel_amp1_ctrl) begin
            next_amp1_ctrl = wbyte;
            // (R3) pin select clears ref
            if (wbyte[`CTRL_POS_PIN_BIT]) begin
                next_amp1_ctrl[`CTRL_REF_HI_BIT:`CTRL_REF_LO_BIT] = 2'b00;
            end
        end
        // (R2) disabled clears feedback
        if (!next_amp1_ctrl[`CTRL_ENABLE_BIT]) begin
            next_amp1_ctrl[`CTRL_FEEDBACK_BIT] = 1'b0;
        end
    end

    // Amplifier two control and route-gain, written together
    always_comb begin
        next_amp2_ctrl  = amp2_ctrl_reg;
        next_route_gain = amp2_route_gain_reg;
        if (wr_low && sel_route_gain) begin
            // (R20) bits 5,4 unimplemented
            next_route_gain = wbyte & `RG_USED_MASK;
        end
        if (wr_low && sel_amp2_ctrl) begin
            next_amp2_ctrl = wbyte;
            // (R6) positive pin clears
            if (wbyte[`CTRL_POS_PIN_BIT]) begin
                next_amp2_ctrl[`CTRL_REF_HI_BIT:`CTRL_REF_LO_BIT] = 2'b00;
                next_route_gain[`RG_POS_ROUTE_BIT] = 1'b0;
            end
            // (R7) negative pin clears
            if (wbyte[`CTRL_NEG_PIN_BIT]) begin
                next_route_gain[`RG_NEG_ROUTE_BIT] = 1'b0;
            end
        end
        // (R5) disabled clears bits
        if (!next_amp2_ctrl[`CTRL_ENABLE_BIT]) begin
            next_amp2_ctrl[`CTRL_FEEDBACK_BIT] = 1'b0;
            next_route_gain[`RG_GAIN_EN_BIT]   = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // (R22) interlocks land with the write
    // Amplifier one control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp1_ctrl_reg <= `CTRL_RESET;
        end else begin
            amp1_ctrl_reg <= next_amp1_ctrl;
        end
    end

    // Amplifier two control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp2_ctrl_reg <= `CTRL_RESET;
        end else begin
            amp2_ctrl_reg <= next_amp2_ctrl;
        end
    end

    // Route and gain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp2_route_gain_reg <= `ROUTE_GAIN_RESET;
        end else begin
            amp2_route_gain_reg <= next_route_gain;
        end
    end

    // ------------------------------------------------------------------
    // Comparator source
    // ------------------------------------------------------------------
    // (R21) comparator source, resets to pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_src <= `CMP_SRC_RESET;
        end else if (wr_low && sel_cmp_src) begin
            cmp_src <= wbyte[`CMP_SRC_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Captured in the setup cycle, stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                // (R1) level in bit 7
                `AMP1_STATUS_OFS:     prdata <= {24'h0, status_byte(amp1_lvl)};
                `AMP2_STATUS_OFS:     prdata <= {24'h0, status_byte(amp2_lvl)};
                `AMP1_CTRL_OFS:       prdata <= {24'h0, amp1_ctrl_reg};
                `AMP2_CTRL_OFS:       prdata <= {24'h0, amp2_ctrl_reg};
                `AMP2_ROUTE_GAIN_OFS: prdata <= {24'h0, amp2_route_gain_reg};
                `CMP_SRC_OFS:         prdata <= {31'h0, cmp_src};
                default:              prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Switch decode
    // ------------------------------------------------------------------
    // (R23) pure decode of register bits
    assign amp1_ref = ref_of(amp1_ctrl_reg);
    assign amplifier_one_en = amp1_ctrl_reg[`CTRL_ENABLE_BIT];
    assign amplifier_two_en = amp2_ctrl_reg[`CTRL_ENABLE_BIT];
    // (R19) separate output enables
    assign amp1_out_pin_en  = amp1_ctrl_reg[`CTRL_OUT_PIN_BIT];
    assign amp2_out_pin_en  = amp2_ctrl_reg[`CTRL_OUT_PIN_BIT];
    // (R17) amp1 pin switches
    assign amp1_pos_pin_switch = amp1_ctrl_reg[`CTRL_POS_PIN_BIT];
    assign amp1_neg_pin_switch = amp1_ctrl_reg[`CTRL_NEG_PIN_BIT];
    // (R16) feedback open when disabled
    assign amp1_feedback_switch = amp1_ctrl_reg[`CTRL_FEEDBACK_BIT]
                               && amplifier_one_en;
    // (R15) comparator route switch
    assign amp1_cmp_switch = amp1_ctrl_reg[`CTRL_CMP_ROUTE_BIT];
    // (R4) reference decode
    assign high_ref_switch = (amp1_ref == ref_high);
    assign mid_ref_switch  = (amp1_ref == ref_mid);
    assign low_ref_switch  = (amp1_ref == ref_low);

    // ------------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------------
    // (R18) pin function ownership
    assign amp1_out_pin_func = amplifier_one_en;
    assign amp1_pos_pin_func = amplifier_one_en && amp1_pos_pin_switch;
    assign amp1_neg_pin_func = amplifier_one_en && amp1_neg_pin_switch;

    // ------------------------------------------------------------------
    // Amplifier two controls passed out for its own decode
    // ------------------------------------------------------------------
    assign amp2_pos_pin_switch  = amp2_ctrl_reg[`CTRL_POS_PIN_BIT];
    assign amp2_neg_pin_switch  = amp2_ctrl_reg[`CTRL_NEG_PIN_BIT];
    assign amp2_feedback_sw_ctl = amp2_ctrl_reg[`CTRL_FEEDBACK_BIT]
                               && amplifier_two_en;
    assign amp2_cmp_switch      = amp2_ctrl_reg[`CTRL_CMP_ROUTE_BIT];
    assign amp2_ref_sel         = ref_of(amp2_ctrl_reg);
    assign amp1_to_amp2_neg = amp2_route_gain_reg[`RG_NEG_ROUTE_BIT];
    assign amp1_to_amp2_pos = amp2_route_gain_reg[`RG_POS_ROUTE_BIT];

    // ------------------------------------------------------------------
    // Gain
    // ------------------------------------------------------------------
    // (R9) gain only when enabled
    assign gain_active = amp2_route_gain_reg[`RG_GAIN_EN_BIT]
                      && amplifier_two_en;
    assign gain_sel    = amp2_route_gain_reg[`RG_GAIN_HI_BIT:`RG_GAIN_LO_BIT];
    assign gain_value  = gain_active ? gain_of(gain_sel) : 6'h01;
    assign cmp_pos_src_sel = cmp_src;

endmodule // opamp_switch_control_regs

`default_nettype wire

// [verif/opamp_switch_asserts.sv]
// Port assertions for the amplifier control bank
`timescale 1ns/1ps
`default_nettype none

module opamp_switch_asserts import opamp_switch_pkg::*; (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [11:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        amplifier_one_en,
    input wire logic                        amplifier_two_en,
    input wire logic                        amp1_feedback_switch,
    input wire logic                        high_ref_switch,
    input wire logic                        mid_ref_switch,
    input wire logic                        low_ref_switch,
    input wire logic                        amp1_out_pin_func,
    input wire logic                        amp2_feedback_sw_ctl,
    input wire logic                        gain_active,
    input wire opamp_switch_pkg::gain_sel_t gain_sel,
    input wire logic [5:0]                  gain_value
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_FB1_OPEN: assert property (
        !amplifier_one_en |-> !amp1_feedback_switch)
        else $error("amp1 feedback closed while disabled");
    AST_REF_ONE: assert property (
        $onehot0({high_ref_switch, mid_ref_switch, low_ref_switch}))
        else $error("two reference switches closed");
    AST_POS_CLR: assert property (
        psel && penable && pwrite && paddr == 12'h004 && pwdata[3]
        && pstrb[0] |=> !(high_ref_switch | mid_ref_switch | low_ref_switch))
        else $error("reference kept after pin select write");
    AST_AMP2_OFF: assert property (
        !amplifier_two_en |-> !gain_active && !amp2_feedback_sw_ctl)
        else $error("amp2 gain or feedback on while disabled");
    AST_GAIN_VAL: assert property (
        gain_active |-> gain_value == ((gain_sel == 3'h0) ? 6'h01
                                       : {gain_sel, 3'h0}))
        else $error("gain value does not match code");
    AST_GAIN_IDLE: assert property (
        !gain_active |-> gain_value == 6'h01)
        else $error("gain applied while disabled");
    AST_OUT_FUNC: assert property (
        amp1_out_pin_func == amplifier_one_en)
        else $error("amp1 output pin use wrong");
    AST_READY: assert property (
        psel && penable |-> pready)
        else $error("access phase not ready");
    AST_UNMAP: assert property (
        psel && penable && paddr > 12'h014 |-> pslverr)
        else $error("unmapped access without error");
endmodule // opamp_switch_asserts

bind opamp_switch_control_regs opamp_switch_asserts i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .amplifier_one_en, .amplifier_two_en,
    .amp1_feedback_switch, .high_ref_switch, .mid_ref_switch,
    .low_ref_switch, .amp1_out_pin_func, .amp2_feedback_sw_ctl,
    .gain_active, .gain_sel, .gain_value);

`default_nettype wire

// [verif/opamp_switch_control_regs_tb.sv]
// Self-checking bench for the amplifier control bank
`timescale 1ns/1ps
`default_nettype none
`include "opamp_switch_params.svh"

module opamp_switch_control_regs_tb;
    import opamp_switch_pkg::*;
    localparam logic [11:0] st1 = `AMP1_STATUS_OFS, ct1 = `AMP1_CTRL_OFS;
    localparam logic [11:0] st2 = `AMP2_STATUS_OFS, ct2 = `AMP2_CTRL_OFS;
    localparam logic [11:0] rgg = `AMP2_ROUTE_GAIN_OFS, cms = `CMP_SRC_OFS;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, amp1_out_level = 1'b0, amp2_out_level = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, amplifier_one_en, amplifier_two_en;
    logic        amp1_out_pin_en, amp2_out_pin_en, amp1_pos_pin_switch;
    logic        amp1_neg_pin_switch, amp1_feedback_switch, amp1_cmp_switch;
    logic        high_ref_switch, mid_ref_switch, low_ref_switch;
    logic        amp1_pos_pin_func, amp1_neg_pin_func, amp1_out_pin_func;
    logic        amp2_pos_pin_switch, amp2_neg_pin_switch, amp2_cmp_switch;
    logic        amp2_feedback_sw_ctl, amp1_to_amp2_neg, amp1_to_amp2_pos;
    logic        gain_active, cmp_pos_src_sel;
    ref_sel_e    amp2_ref_sel;
    gain_sel_t   gain_sel;
    logic [5:0]  gain_value;
    logic [7:0]  r8;
    logic [32:0] notes[$];
    int          fail_count = 0, comparisons = 0;

    opamp_switch_control_regs i_dut (.*);

    // Clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input string n, input logic [32:0] e, s);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the note holds error flag and read data
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [3:0] s,
                       input logic err);
        logic [31:0] r;
        int          n;
        r = $urandom;
        notes.push_back({err, w ? 32'h0 : {24'h0, d}});
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {r[31:8], d};
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            fail_count++;
            close_out();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hf, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, e, 4'hf, 1'b0);
    endtask

    // Compare each completed transfer with its oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                check("note", 33'h0, 33'h1);
            end else begin
                check("answer", notes.pop_front(),
                      {pslverr, pwrite ? 32'h0 : prdata});
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'he0b5));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ct1, 8'h0c);
        rd(ct2, 8'h0c);
        rd(rgg, 8'h00);
        rd(cms, 8'h01);
        check("src", 1'b1, cmp_pos_src_sel);
        check("rst", 6'h3c, {amp1_pos_pin_switch, amp1_neg_pin_switch,
              amp2_pos_pin_switch, amp2_neg_pin_switch, amplifier_one_en,
              amplifier_two_en});
        @(posedge pclk);
        amp1_out_level <= 1'b1;
        wr(st1, 8'h00);
        rd(st1, 8'h80);
        rd(st2, 8'h00);
        wr(ct1, 8'h41);
        check("fb1", 1'b1, amp1_feedback_switch);
        wr(ct1, 8'h40);
        rd(ct1, 8'h00);
        wr(ct1, 8'h31);
        check("lo", 1'b1, low_ref_switch);
        wr(ct1, 8'h39);
        rd(ct1, 8'h09);
        for (int k = 0; k < 4; k++) begin
            wr(ct1, {2'b00, k[1:0], 4'h1});
            wr(ct2, {2'b00, k[1:0], 4'h1});
            check("ref", {k == 1, k == 2, k == 3}, {high_ref_switch,
                  mid_ref_switch, low_ref_switch});
            check("ref2", k[1:0], amp2_ref_sel);
        end
        wr(ct1, 8'h8f);
        check("p1", 5'h1f, {amp1_cmp_switch, amp1_out_pin_en,
              amp1_pos_pin_func, amp1_neg_pin_func, amp1_out_pin_func});
        wr(ct1, 8'h8e);
        check("p0", 5'h18, {amp1_cmp_switch, amp1_out_pin_en,
              amp1_pos_pin_func, amp1_neg_pin_func, amp1_out_pin_func});
        @(posedge pclk);
        amp2_out_level <= 1'b1;
        wr(ct2, 8'h43);
        wr(rgg, 8'h08);
        check("ga", 1'b1, gain_active);
        check("a2", 3'h7, {amp2_feedback_sw_ctl, amp2_out_pin_en,
              amplifier_two_en});
        wr(ct2, 8'h00);
        rd(rgg, 8'h00);
        rd(ct2, 8'h00);
        wr(rgg, 8'hc0);
        check("rt", 2'h3, {amp1_to_amp2_neg, amp1_to_amp2_pos});
        wr(ct2, 8'h31);
        wr(ct2, 8'h39);
        check("rt2", 4'ha, {amp1_to_amp2_neg, amp1_to_amp2_pos,
              amp2_pos_pin_switch, amp2_neg_pin_switch});
        rd(ct2, 8'h09);
        rd(rgg, 8'h80);
        wr(ct2, 8'h05);
        check("rt3", 4'h1, {amp1_to_amp2_neg, amp1_to_amp2_pos,
              amp2_pos_pin_switch, amp2_neg_pin_switch});
        rd(rgg, 8'h00);
        wr(ct2, 8'h01);
        for (int g = 0; g < 8; g++) begin
            r8 = $urandom;
            wr(rgg, {2'b00, r8[5:4], 1'b1, g[2:0]});
            rd(rgg, {4'h0, 1'b1, g[2:0]});
            check("gain", (g == 0) ? 6'd1 : 6'(g * 8), gain_value);
        end
        apb(1'b1, rgg, 8'h00, 4'he, 1'b0);
        rd(rgg, 8'h0f);
        wr(rgg, 8'h07);
        check("gi", 7'h01, {gain_active, gain_value});
        apb(1'b1, 12'h020, 8'hff, 4'hf, 1'b1);
        apb(1'b0, 12'h020, 8'h00, 4'hf, 1'b1);
        wr(cms, 8'h00);
        check("src0", 1'b0, cmp_pos_src_sel);
        wr(ct1, 8'h80);
        check("c1", 1'b1, amp1_cmp_switch);
        wr(ct1, 8'h00);
        wr(ct2, 8'h81);
        check("c2", 2'h1, {amp1_cmp_switch, amp2_cmp_switch});
        rd(st2, 8'h80);
        close_out();
    end
endmodule // opamp_switch_control_regs_tb

`default_nettype wire
